/* File: include/ssm_pkg.sv */
// constants for the scanner stepper motor control block
// assumes a single core clock and 32-bit axi4-lite register access
package ssm_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_KEEP      = 8'h43;
  localparam logic [7:0] IDX_PERIOD    = 8'h44;
  localparam logic [7:0] IDX_CFG       = 8'h45;
  localparam logic [7:0] IDX_SCAN_HI   = 8'h46;
  localparam logic [7:0] IDX_SCAN_LO   = 8'h47;
  localparam logic [7:0] IDX_FEED_HI   = 8'h48;
  localparam logic [7:0] IDX_FEED_LO   = 8'h49;
  localparam logic [7:0] IDX_SKIP_HI   = 8'h4a;
  localparam logic [7:0] IDX_SKIP_LO   = 8'h4b;
  localparam logic [7:0] IDX_CNT_HI    = 8'h4c;
  localparam logic [7:0] IDX_CNT_LO    = 8'h4d;
  localparam logic [7:0] IDX_PHASE     = 8'h54;
  localparam logic [7:0] IDX_CMD       = 8'h60;
  localparam logic [7:0] IDX_STATUS    = 8'h61;

  // ==========================================================
  // motor drive config field positions
  localparam int CFG_MICRO   = 0;
  localparam int CFG_SENSE   = 1;
  localparam int CFG_POL_A   = 2;
  localparam int CFG_POL_B   = 3;
  localparam int CFG_ACTIVE  = 4;
  localparam int CFG_SWAP    = 5;
  localparam int CFG_FF_FULL = 6;

  // command bits and phase delay field position
  localparam int CMD_START   = 0;
  localparam int CMD_STOP    = 1;
  localparam int PH_DLY_LSB  = 4;

  // ==========================================================
  // reset values and limits
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] MIN_STEP     = 16'h0002;
  localparam logic [8:0]  KEEP_BASE    = 9'h100;
  localparam int          PIX_DIV      = 4;
  localparam int          MICRO_STEPS  = 8;
  localparam int          CNT_W        = 14;
  localparam int          SKIP_W       = 15;

endpackage

/* File: include/ssm_step_if.sv */
// step timer connection between motor control and its timer
// assumes both ends share the core clock
`timescale 1ns/1ps
`default_nettype none
interface ssm_step_if;
  logic [15:0] period;
  logic        run;
  logic        restart;
  logic        step;
  modport ctrl  (output period, output run, output restart, input step);
  modport timer (input period, input run, input restart, output step);
endinterface
`default_nettype wire

/* File: rtl/ssm_step_timer.sv */
// pixel-period divider and microstep period counter
// assumes period is already clamped to the legal minimum
`timescale 1ns/1ps
`default_nettype none
module ssm_step_timer
  import ssm_pkg::*;
#(
  parameter int PIX_CYCLES = PIX_DIV
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // timer side of the step interface
  ssm_step_if.timer tmr
);

  if (PIX_CYCLES < 1 || PIX_CYCLES > 65535) begin : g_chk
    $error("PIX_CYCLES out of range");
  end

  // ==========================================================
  // pixel period enable
  logic [15:0] divCnt_q;
  logic [15:0] pixCnt_q;
  logic        step_q;
  wire         pixTick = (divCnt_q == 16'(PIX_CYCLES - 1));
  wire         expire  = pixTick && (pixCnt_q + 16'h0001 >= tmr.period);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 16'h0000;
    end else if (!tmr.run || tmr.restart || pixTick) begin
      divCnt_q <= 16'h0000;
    end else begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // count pixel periods, pulse at the programmed size
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pixCnt_q <= 16'h0000;
      step_q   <= 1'b0;
    end else begin
      step_q <= tmr.run && !tmr.restart && expire;
      if (!tmr.run || tmr.restart || expire) begin
        pixCnt_q <= 16'h0000;
      end else if (pixTick) begin
        pixCnt_q <= pixCnt_q + 16'h0001;
      end
    end
  end

  assign tmr.step = step_q;

endmodule
`default_nettype wire

/* File: rtl/ssm_motor_ctrl.sv */
// scanner stepper motor control: registers, step sequencing,
// winding outputs and n-out-of-m line selection
// assumes lineSync is a one-cycle pulse from logic on core_clk
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - keep n of every m lines, n=256-t
// - t of zero keeps every line
// - group length m from own byte
// - phase register bits 4-7 also steer skipping
// - full-step mode: no microsteps, whole steps
// - phase A polarity picks energised level
// - phase B polarity picks energised level
// - config bit four clear floats all four outputs
// - swap bit exchanges phase A and B pairs
// - fast-feed full-step option uses whole steps
// - scan microstep period, minimum two
// - feed microstep period, minimum two
// - start skips programmed full steps at speed
// - fourteen-bit full-step counter, readable
module ssm_motor_ctrl
  import ssm_pkg::*;
#(
  parameter int PIX_CYCLES = PIX_DIV,
  parameter int MICRO_PER  = MICRO_STEPS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // line timing
  input  wire logic        lineSync,
  output logic             lineKeep,
  // winding outputs and enables
  output logic [3:0]       windOut,
  output logic [3:0]       windOe
);

  if (MICRO_PER < 2 || MICRO_PER > 256) begin : g_chk
    $error("MICRO_PER out of range");
  end

  typedef enum logic [1:0] {S_IDLE, S_SKIP, S_SCAN} ssm_state_e;

  // ==========================================================
  // register state
  logic [7:0]  keep_q;
  logic [7:0]  period_q;
  logic [7:0]  cfg_q;
  logic [7:0]  scanHi_q;
  logic [7:0]  scanLo_q;
  logic [7:0]  feedHi_q;
  logic [7:0]  feedLo_q;
  logic [7:0]  skipHi_q;
  logic [7:0]  skipLo_q;
  logic [7:0]  phase_q;
  logic [CNT_W-1:0]  fullCnt_q;
  logic [SKIP_W-1:0] skipDone_q;
  logic [7:0]  microIdx_q;
  logic [1:0]  seqIdx_q;
  logic [7:0]  linePos_q;
  ssm_state_e  state_q;

  // ==========================================================
  // axi4-lite slave state
  logic        awReady_q;
  logic        wReady_q;
  logic [7:0]  awIdx_q;
  logic [7:0]  wData_q;
  logic        wLane_q;
  logic        bValid_q;
  logic [1:0]  bResp_q;
  logic        arReady_q;
  logic        rValid_q;
  logic [31:0] rData_q;
  logic [1:0]  rResp_q;

  wire awTake = s_axi_awvalid && awReady_q;
  wire wTake  = s_axi_wvalid && wReady_q;
  wire arTake = s_axi_arvalid && arReady_q;
  wire doWr   = !awReady_q && !wReady_q && !bValid_q;
  wire wrEn   = doWr && wLane_q;

  // ==========================================================
  // address decode
  wire selKeep   = (awIdx_q == IDX_KEEP);
  wire selPeriod = (awIdx_q == IDX_PERIOD);
  wire selCfg    = (awIdx_q == IDX_CFG);
  wire selScanHi = (awIdx_q == IDX_SCAN_HI);
  wire selScanLo = (awIdx_q == IDX_SCAN_LO);
  wire selFeedHi = (awIdx_q == IDX_FEED_HI);
  wire selFeedLo = (awIdx_q == IDX_FEED_LO);
  wire selSkipHi = (awIdx_q == IDX_SKIP_HI);
  wire selSkipLo = (awIdx_q == IDX_SKIP_LO);
  wire selPhase  = (awIdx_q == IDX_PHASE);
  wire selCmd    = (awIdx_q == IDX_CMD);
  wire wrRo      = (awIdx_q == IDX_CNT_HI) || (awIdx_q == IDX_CNT_LO)
                || (awIdx_q == IDX_STATUS);
  wire wrHit     = selKeep || selPeriod || selCfg || selScanHi
                || selScanLo || selFeedHi || selFeedLo || selSkipHi
                || selSkipLo || selPhase || selCmd || wrRo;
  wire startCmd  = wrEn && selCmd && wData_q[CMD_START];
  wire stopCmd   = wrEn && selCmd && wData_q[CMD_STOP];

  // ==========================================================
  // read mux, unused upper bits read as zero
  wire [7:0] arIdx = s_axi_araddr[9:2];
  wire [7:0] stat  = {5'h00, cfg_q[CFG_SENSE], state_q == S_SCAN,
                      state_q != S_IDLE};
  wire [7:0] rdByte =
    (arIdx == IDX_KEEP)    ? keep_q :
    (arIdx == IDX_PERIOD)  ? period_q :
    (arIdx == IDX_CFG)     ? cfg_q :
    (arIdx == IDX_SCAN_HI) ? scanHi_q :
    (arIdx == IDX_SCAN_LO) ? scanLo_q :
    (arIdx == IDX_FEED_HI) ? feedHi_q :
    (arIdx == IDX_FEED_LO) ? feedLo_q :
    (arIdx == IDX_SKIP_HI) ? skipHi_q :
    (arIdx == IDX_SKIP_LO) ? skipLo_q :
    (arIdx == IDX_CNT_HI)  ? {2'b00, fullCnt_q[13:8]} :
    (arIdx == IDX_CNT_LO)  ? fullCnt_q[7:0] :
    (arIdx == IDX_PHASE)   ? phase_q :
    (arIdx == IDX_STATUS)  ? stat : 8'h00;
  wire rdHit = (arIdx >= IDX_KEEP && arIdx <= IDX_CNT_LO)
            || arIdx == IDX_PHASE || arIdx == IDX_CMD
            || arIdx == IDX_STATUS;
  wire addrOk = s_axi_araddr[1:0] == 2'b00
             && s_axi_araddr[31:10] == 22'h000000;

  // ==========================================================
  // write channel handshakes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      awIdx_q   <= 8'h00;
      wData_q   <= 8'h00;
      wLane_q   <= 1'b0;
    end else begin
      if (awTake) begin
        awReady_q <= 1'b0;
        awIdx_q   <= (s_axi_awaddr[31:10] == 22'h000000)
                   ? s_axi_awaddr[9:2] : 8'hff;
      end
      if (wTake) begin
        wReady_q <= 1'b0;
        wData_q  <= s_axi_wdata[7:0];
        wLane_q  <= s_axi_wstrb[0];
      end
      if (bValid_q && s_axi_bready) begin
        awReady_q <= 1'b1;
        wReady_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bValid_q <= 1'b0;
      bResp_q  <= 2'b00;
    end else if (doWr) begin
      bValid_q <= 1'b1;
      bResp_q  <= wrHit ? 2'b00 : 2'b10;
    end else if (bValid_q && s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h00000000;
      rResp_q   <= 2'b00;
    end else if (arTake) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b1;
      rData_q   <= {24'h000000, rdHit && addrOk ? rdByte : 8'h00};
      rResp_q   <= rdHit && addrOk ? 2'b00 : 2'b10;
    end else if (rValid_q && s_axi_rready) begin
      arReady_q <= 1'b1;
      rValid_q  <= 1'b0;
    end
  end

  // ==========================================================
  // software-written settings
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      keep_q   <= BYTE_RST;
      period_q <= BYTE_RST;
      cfg_q    <= CFG_RST;
      scanHi_q <= BYTE_RST;
      scanLo_q <= BYTE_RST;
      feedHi_q <= BYTE_RST;
      feedLo_q <= BYTE_RST;
      skipHi_q <= BYTE_RST;
      skipLo_q <= BYTE_RST;
      phase_q  <= BYTE_RST;
    end else if (wrEn) begin
      if (selKeep)   keep_q   <= wData_q;
      if (selPeriod) period_q <= wData_q;
      if (selCfg)    cfg_q    <= {1'b0, wData_q[6:0]};
      if (selScanHi) scanHi_q <= wData_q;
      if (selScanLo) scanLo_q <= wData_q;
      if (selFeedHi) feedHi_q <= {2'b00, wData_q[5:0]};
      if (selFeedLo) feedLo_q <= wData_q;
      if (selSkipHi) skipHi_q <= {1'b0, wData_q[6:0]};
      if (selSkipLo) skipLo_q <= wData_q;
      if (selPhase)  phase_q  <= {wData_q[7:3], 3'b000};
    end
  end

  // ==========================================================
  // step timing selection, clamped to the minimum of two
  wire [15:0] scanPer = {scanHi_q, scanLo_q};
  wire [15:0] feedPer = {feedHi_q, feedLo_q};
  wire [15:0] scanUse = (scanPer < MIN_STEP) ? MIN_STEP : scanPer;
  wire [15:0] feedUse = (feedPer < MIN_STEP) ? MIN_STEP : feedPer;
  wire [SKIP_W-1:0] skipTgt = {skipHi_q[6:0], skipLo_q};
  wire useFull = !cfg_q[CFG_MICRO]
              || (state_q == S_SKIP && cfg_q[CFG_FF_FULL]);

  ssm_step_if stp ();
  assign stp.period  = (state_q == S_SKIP) ? feedUse : scanUse;
  assign stp.run     = (state_q != S_IDLE);
  assign stp.restart = startCmd || stopCmd;

  ssm_step_timer #(
    .PIX_CYCLES (PIX_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .tmr      (stp.timer)
  );

  wire microWrap = (microIdx_q == 8'(MICRO_PER - 1));
  wire fullStep  = stp.step && (useFull || microWrap);
  wire skipLast  = fullStep && (skipDone_q + 15'h0001 >= skipTgt);

  // ==========================================================
  // scan sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else if (stopCmd) begin
      state_q <= S_IDLE;
    end else if (startCmd) begin
      state_q <= (skipTgt == 15'h0000) ? S_SCAN : S_SKIP;
    end else begin
      unique case (state_q)
        S_IDLE: state_q <= S_IDLE;
        S_SKIP: if (skipLast) begin
          state_q <= S_SCAN;
        end
        S_SCAN: state_q <= S_SCAN;
      endcase
    end
  end

  // ==========================================================
  // microstep, full-step phase and counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      microIdx_q <= 8'h00;
      seqIdx_q   <= 2'b00;
      fullCnt_q  <= '0;
      skipDone_q <= '0;
    end else if (startCmd) begin
      microIdx_q <= 8'h00;
      fullCnt_q  <= '0;
      skipDone_q <= '0;
    end else if (stp.step) begin
      microIdx_q <= (useFull || microWrap) ? 8'h00
                  : microIdx_q + 8'h01;
      if (fullStep) begin
        seqIdx_q  <= seqIdx_q + 2'b01;
        fullCnt_q <= fullCnt_q + 14'h0001;
        if (state_q == S_SKIP) begin
          skipDone_q <= skipDone_q + 15'h0001;
        end
      end
    end
  end

  // ==========================================================
  // winding pattern, polarity, swap and float control
  wire       energA = stp.run && !seqIdx_q[1];
  wire       energB = stp.run && (seqIdx_q[0] ^ seqIdx_q[1]);
  wire       idleA  = !stp.run;
  wire [1:0] pairA  = idleA ? 2'b00
                    : {energA, !energA} ^ {2{cfg_q[CFG_POL_A]}};
  wire [1:0] pairB  = idleA ? 2'b00
                    : {energB, !energB} ^ {2{cfg_q[CFG_POL_B]}};
  wire [3:0] pinNext = cfg_q[CFG_SWAP] ? {pairA, pairB}
                                       : {pairB, pairA};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      windOut <= 4'h0;
      windOe  <= 4'h0;
    end else begin
      windOut <= pinNext;
      windOe  <= {4{cfg_q[CFG_ACTIVE]}};
    end
  end

  // ==========================================================
  // n-out-of-m line selection
  wire [8:0] keepN   = KEEP_BASE - {1'b0, keep_q};
  wire [8:0] grpLen  = (period_q == 8'h00) ? KEEP_BASE
                                           : {1'b0, period_q};
  wire [8:0] phDly   = {5'h00, phase_q[7:PH_DLY_LSB]};
  wire [8:0] posW    = {1'b0, linePos_q};
  wire       inWin   = posW >= phDly && (posW - phDly) < keepN;
  wire       keepNow = (keep_q == 8'h00) || inWin;
  wire       posWrap = (posW + 9'h001 >= grpLen);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      linePos_q <= 8'h00;
      lineKeep  <= 1'b0;
    end else if (state_q != S_SCAN) begin
      linePos_q <= 8'h00;
      lineKeep  <= 1'b0;
    end else if (lineSync) begin
      linePos_q <= posWrap ? 8'h00 : linePos_q + 8'h01;
      lineKeep  <= keepNow;
    end else begin
      lineKeep  <= 1'b0;
    end
  end

  // ==========================================================
  // bus outputs
  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

endmodule
`default_nettype wire

/* File: verif/ssm_monitor.sv */
// assertions on the ports of the stepper motor control block
// assumes one core clock domain and a bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module ssm_monitor #(
  parameter int PIX_CYCLES = 1,
  parameter int MICRO_PER  = 2
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // line timing and windings
  input wire logic       lineSync,
  input wire logic       lineKeep,
  input wire logic [3:0] windOut,
  input wire logic [3:0] windOe
);
  localparam int MIN_GAP = 2 * PIX_CYCLES;
  // ==========================================================
  // helper counters: cycles since last winding change and last write
  logic [15:0] gapQ;
  logic [3:0]  wrAgeQ;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gapQ   <= 16'h0;
      wrAgeQ <= 4'h0;
    end else begin
      gapQ   <= $changed(windOut) ? 16'h1 : gapQ + {15'h0, ~&gapQ};
      wrAgeQ <= s_axi_bvalid ? 4'h0 : wrAgeQ + {3'h0, ~&wrAgeQ};
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_oe_uniform: assert property (windOe == 4'h0 || windOe == 4'hf)
    else $error("winding enables differ");
  a_pair_a_legal: assert property (windOut[0] == windOut[1] |->
    windOut[1:0] == 2'b00) else $error("phase a pins clash");
  a_pair_b_legal: assert property (windOut[2] == windOut[3] |->
    windOut[3:2] == 2'b00) else $error("phase b pins clash");
  a_keep_cause: assert property (lineKeep |-> $past(lineSync))
    else $error("line kept without a line");
  a_step_gap: assert property ($changed(windOut) && windOut != 4'h0 &&
    $past(windOut) != 4'h0 && wrAgeQ > 4'h4 |-> gapQ >= MIN_GAP)
    else $error("steps too close");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_ready_held: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_resp_legal: assert property (s_axi_bvalid |->
    s_axi_bresp inside {2'b00, 2'b10}) else $error("bad write response");
endmodule
`default_nettype wire

/* File: verif/ssm_wind_model.sv */
// power driver stage at the far side, seen as four pin levels
// assumes windOe high means the block drives that pin
`timescale 1ns/1ps
`default_nettype none
module ssm_wind_model (
  // clock
  input  wire logic       core_clk,
  // winding drive from the block
  input  wire logic [3:0] windOut,
  input  wire logic [3:0] windOe,
  // resolved pin levels
  output logic      [3:0] pinLvl
);
  logic [3:0] lastQ = 4'h0;
  // a floating pin toggles so that a stale level never passes
  assign pinLvl = (windOe & windOut) | (~windOe & ~lastQ);
  always_ff @(posedge core_clk) begin
    lastQ <= pinLvl;
  end
endmodule
`default_nettype wire

/* File: verif/scanner_stepper_motor_control_bench.sv */
// self-checking bench for the stepper motor control block
// assumes package, interface, design, monitor and model compiled first
`timescale 1ns/1ps
`default_nettype none
module scanner_stepper_motor_control_bench;
  import ssm_pkg::*;
  localparam int PX = 1;
  localparam int MP = 2;
  localparam logic [7:0] MSK [10] = '{8'hff, 8'hff, 8'h7f, 8'hff,
    8'hff, 8'h3f, 8'hff, 8'h7f, 8'hff, 8'h00};
  // ==========================================================
  // signals
  logic        core_clk = 1'b0, rst = 1'b1, lineSync = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, lineKeep;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0]  windOut, windOe, pinLvl;
  int          fails = 0, checked = 0;
  always #2.5 core_clk = ~core_clk;
  ssm_motor_ctrl #(.PIX_CYCLES(PX), .MICRO_PER(MP)) ssm_motor_ctrl_i (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .lineSync, .lineKeep, .windOut, .windOe);
  ssm_wind_model ssm_wind_model_i (.core_clk, .windOut, .windOe, .pinLvl);
  // ==========================================================
  // tasks
  task automatic final_report();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] ix, d, output logic [1:0] r);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= {22'h0, ix, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(a && w)) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) a = 1'b1;
      if (s_axi_wready === 1'b1) w = 1'b1;
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ix, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= {22'h0, ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic w8(input logic [7:0] ix, d);
    logic [1:0] r;
    wr(ix, d, r);
    chk(r, 2'b00);
  endtask
  task automatic rc(input logic [7:0] ix, input logic [31:0] want);
    logic [31:0] d;
    logic [1:0]  r;
    rd(ix, d, r);
    chk(d, want);
    chk(r, 2'b00);
  endtask
  // next change of the pins and the cycles it took
  task automatic wch(output logic [3:0] v, output int c);
    logic [3:0] p;
    p = pinLvl;
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (pinLvl === p && c < 5000);
    v = pinLvl;
  endtask
  function automatic logic [3:0] pat(input int s, input logic [7:0] c);
    logic ea, eb;
    logic [1:0] a, b;
    ea = !s[1];
    eb = s[0] ^ s[1];
    a = {!ea ^ c[2], ea ^ c[2]};
    b = {!eb ^ c[3], eb ^ c[3]};
    return c[5] ? {a, b} : {b, a};
  endfunction
  task automatic motor(input logic [7:0] c, sk, input bit tm);
    logic [3:0]  v [6];
    int          dt [6];
    int          s0, ca;
    logic [31:0] d;
    logic [1:0]  r;
    s0 = 0;
    w8(IDX_SKIP_LO, sk);
    w8(IDX_CFG, c);
    w8(IDX_CMD, 8'h01);
    for (int i = 0; i < 6; i++) wch(v[i], dt[i]);
    for (int s = 0; s < 4; s++) if (pat(s, c) === v[1]) s0 = s;
    for (int i = 1; i < 6; i++)
      chk(v[i], pat(s0 + i - 1, c));
    chk(dt[5], (c[0] ? MP : 1) * 20 * PX);
    if (tm) begin
      chk(dt[2], (c[0] && !c[6] ? MP : 1) * 2 * PX);
      rd(IDX_STATUS, d, r);
      chk(d[1], 1'b1);
      rd(IDX_CNT_LO, d, r);
      ca = d;
      wch(v[0], dt[0]);
      rd(IDX_CNT_LO, d, r);
      chk(d, ca + 1);
    end
    w8(IDX_CMD, 8'h02);
    repeat (3) @(posedge core_clk);
    chk(windOut, 4'h0);
  endtask
  task automatic lines(input logic [7:0] t, m, ph, input int want);
    int k;
    k = 0;
    w8(IDX_KEEP, t);
    w8(IDX_PERIOD, m);
    w8(IDX_PHASE, ph);
    w8(IDX_CMD, 8'h01);
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      lineSync <= 1'b1;
      @(posedge core_clk);
      lineSync <= 1'b0;
      @(posedge core_clk);
      k += int'(lineKeep === 1'b1);
    end
    chk(k, want);
    w8(IDX_CMD, 8'h02);
  endtask
  // ==========================================================
  // tests
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rc(8'(IDX_KEEP + i), 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(8'(IDX_KEEP + i), 8'h63, r);
      rc(8'(IDX_KEEP + i), 32'(8'h63 & MSK[i]));
    end
    s_axi_wstrb <= 4'h0;
    w8(IDX_KEEP, 8'h55);
    s_axi_wstrb <= 4'h1;
    rc(IDX_KEEP, 32'h63);
    rd(8'h70, d, r);
    chk(r, 2'b10);
    chk(d, 32'h0);
    wr(8'h70, 8'h11, r);
    chk(r, 2'b10);
    chk(windOe, 4'h0);
    w8(IDX_CFG, 8'h10);
    repeat (2) @(posedge core_clk);
    chk(windOe, 4'hf);
    w8(IDX_SCAN_HI, 8'h00);
    w8(IDX_SCAN_LO, 8'd20);
    w8(IDX_FEED_HI, 8'h00);
    w8(IDX_FEED_LO, 8'h02);
    w8(IDX_SKIP_HI, 8'h00);
    w8(IDX_SKIP_LO, 8'h00);
    lines(8'd0, 8'd4, 8'h00, 8);
    lines(8'd253, 8'd4, 8'h00, 6);
    lines(8'd254, 8'd8, 8'h00, 2);
    lines(8'd254, 8'd4, 8'h30, 2);
    motor(8'h13, 8'd3, 1'b1);
    motor(8'h10, 8'd0, 1'b0);
    motor(8'h30, 8'd0, 1'b0);
    motor(8'h14, 8'd0, 1'b0);
    motor(8'h18, 8'd0, 1'b0);
    w8(IDX_FEED_LO, 8'h01);
    motor(8'h53, 8'd3, 1'b1);
    final_report();
  end
  initial begin
    #(5 * 60000);
    fails++;
    final_report();
  end
endmodule
bind ssm_motor_ctrl ssm_monitor #(.PIX_CYCLES(PIX_CYCLES),
  .MICRO_PER(MICRO_PER)) ssm_monitor_i (.core_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .lineSync, .lineKeep, .windOut, .windOe);
`default_nettype wire
